// file: core/dqlm_core.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module dqlm_core #(
  parameter int unsigned BLOCK_LEN = dqlm_pkg::BLOCK_LEN_DEF,
  parameter int unsigned CNT_W = dqlm_pkg::CNT_W_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic linkInit,
  input wire logic linkDrop,
  input wire logic [dqlm_pkg::LANE_N-1:0] txLaneBits,
  input wire logic txValid,
  output logic txReady,
  output logic [dqlm_pkg::PHASE_W-1:0] txPhaseX_r,
  output logic [dqlm_pkg::PHASE_W-1:0] txPhaseY_r,
  output logic txSymValid_r,
  input wire logic [dqlm_pkg::PHASE_W-1:0] rxPhaseX,
  input wire logic [dqlm_pkg::PHASE_W-1:0] rxPhaseY,
  input wire logic rxSymValid,
  output logic [dqlm_pkg::LANE_N-1:0] rxLaneBits_r,
  output logic rxLaneValid_r,
  input wire logic [dqlm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [dqlm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [dqlm_pkg::DATA_W-1:0] regRdData_r,
  output logic irq
);
  import dqlm_pkg::*;

  localparam int unsigned SLOT_W = $clog2(BLOCK_LEN);
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(BLOCK_LEN - 1);
  // Data bits checked per block; parity symbol excluded
  localparam logic [CNT_W-1:0] BLK_BITS = CNT_W'((BLOCK_LEN - 1) * LANE_N);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  initial
  begin
    if (BLOCK_LEN < 2 || BLOCK_LEN > 65536 || CNT_W < 8 || CNT_W > DATA_W)
      $error("dqlm_core: unsupported BLOCK_LEN or CNT_W");
  end

  // Optical lane k (0 X in-phase .. 3 Y quadrature) takes client lane sel
  function automatic logic [1:0] laneSel(input logic [7:0] map,
                                         input int unsigned k);
    laneSel = map[2*k +: 2];
  endfunction : laneSel

  function automatic logic mapIsPerm(input logic [7:0] map);
    logic [3:0] seen;
    seen = 4'h0;
    for (int unsigned k = 0; k < LANE_N; k++)
      seen[laneSel(map, k)] = 1'b1;
    mapIsPerm = &seen;
  endfunction : mapIsPerm

  function automatic logic [CNT_W-1:0] satAdd(input logic [CNT_W-1:0] v,
                                              input logic [CNT_W-1:0] a);
    logic [CNT_W:0] s;
    s = {1'b0, v} + {1'b0, a};
    satAdd = s[CNT_W] ? CNT_MAX : s[CNT_W-1:0];
  endfunction : satAdd

  dqlm_link_t linkState_r;
  logic [MAP_W-1:0] mapReq_r;
  logic [MAP_W-1:0] mapAct_r;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqEn_r;
  logic [IRQ_W-1:0] irqEvent;
  logic [SLOT_W-1:0] txSlot_r;
  logic [SLOT_W-1:0] rxSlot_r;
  logic [LANE_N-1:0] txPar_r;
  logic [LANE_N-1:0] rxPar_r;
  logic [PHASE_W-1:0] rxPrevX_r;
  logic [PHASE_W-1:0] rxPrevY_r;
  logic [CNT_W-1:0] blocks_r;
  logic [CNT_W-1:0] uncorr_r;
  logic [CNT_W-1:0] errBits_r;
  logic [CNT_W-1:0] chkBits_r;
  logic linkUp;
  logic txParSlot;
  logic txFire;
  logic [LANE_N-1:0] txClient;
  logic [LANE_N-1:0] txOpt;
  logic [1:0] txTurnX;
  logic [1:0] txTurnY;
  logic rxParSlot;
  logic rxFire;
  logic rxBlkEnd;
  logic [LANE_N-1:0] rxOpt;
  logic [1:0] rxPairX;
  logic [1:0] rxPairY;
  logic [LANE_N-1:0] rxClient;
  logic [LANE_N-1:0] rxMismatch;
  logic [CNT_W-1:0] rxErrN;
  logic satHit;

  assign linkUp = (linkState_r == DQLM_UP);

  // Connection state; a fresh init while up starts a new connection
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      linkState_r <= DQLM_DOWN;
    else
    begin
      case (linkState_r)
        DQLM_DOWN: if (linkInit) linkState_r <= DQLM_UP;
        DQLM_UP: if (linkDrop && !linkInit) linkState_r <= DQLM_DOWN;
        default: linkState_r <= DQLM_DOWN;
      endcase
    end
  end

  // Software may rewrite the request at any time; it only bites at init
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      mapAct_r <= MAP_RESET;
    else if (linkInit)
      mapAct_r <= mapIsPerm(mapReq_r) ? mapReq_r : MAP_RESET;
  end

  // Transmit: one parity symbol closes each block, as the RS column does
  assign txParSlot = (txSlot_r == LAST_SLOT);
  assign txReady = linkUp && !txParSlot;
  assign txFire = linkUp && !linkInit && (txParSlot || txValid);
  assign txClient = txParSlot ? txPar_r : txLaneBits;

  always_comb
  begin
    for (int unsigned k = 0; k < LANE_N; k++)
      txOpt[k] = txClient[laneSel(mapAct_r, k)];
    // Same coding per polarization, each on its own lane pair
    txTurnX = dqlmPairToTurn(txOpt[0], txOpt[1]);
    txTurnY = dqlmPairToTurn(txOpt[2], txOpt[3]);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txPhaseX_r <= 2'h0;
      txPhaseY_r <= 2'h0;
      txSymValid_r <= 1'b0;
    end
    else if (linkInit)
    begin
      txPhaseX_r <= 2'h0;
      txPhaseY_r <= 2'h0;
      txSymValid_r <= 1'b0;
    end
    else
    begin
      txSymValid_r <= txFire;
      if (txFire)
      begin
        txPhaseX_r <= txPhaseX_r + txTurnX;
        txPhaseY_r <= txPhaseY_r + txTurnY;
      end
    end
  end

  // Lane parity stands in for the staircase encoder at this level
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txSlot_r <= '0;
      txPar_r <= '0;
    end
    else if (linkInit)
    begin
      txSlot_r <= '0;
      txPar_r <= '0;
    end
    else if (txFire)
    begin
      txSlot_r <= txParSlot ? '0 : txSlot_r + 1'b1;
      txPar_r <= txParSlot ? '0 : (txPar_r ^ txLaneBits);
    end
  end

  // Receive: decode from the step between symbols only
  assign rxFire = linkUp && !linkInit && rxSymValid;
  assign rxParSlot = (rxSlot_r == LAST_SLOT);
  assign rxBlkEnd = rxFire && rxParSlot;

  always_comb
  begin
    rxPairX = dqlmTurnToPair(rxPhaseX - rxPrevX_r);
    rxPairY = dqlmTurnToPair(rxPhaseY - rxPrevY_r);
    // Pair is {first, second}; first bit goes to the in-phase lane
    rxOpt = {rxPairY[0], rxPairY[1], rxPairX[0], rxPairX[1]};
    rxClient = '0;
    for (int unsigned k = 0; k < LANE_N; k++)
      rxClient[laneSel(mapAct_r, k)] = rxOpt[k];
    rxMismatch = rxPar_r ^ rxClient;
    rxErrN = CNT_W'($countones(rxMismatch));
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxPrevX_r <= 2'h0;
      rxPrevY_r <= 2'h0;
    end
    else if (linkInit)
    begin
      rxPrevX_r <= 2'h0;
      rxPrevY_r <= 2'h0;
    end
    else if (rxFire)
    begin
      rxPrevX_r <= rxPhaseX;
      rxPrevY_r <= rxPhaseY;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxSlot_r <= '0;
      rxPar_r <= '0;
      rxLaneBits_r <= '0;
      rxLaneValid_r <= 1'b0;
    end
    else if (linkInit)
    begin
      rxSlot_r <= '0;
      rxPar_r <= '0;
      rxLaneValid_r <= 1'b0;
    end
    else
    begin
      rxLaneValid_r <= rxFire && !rxParSlot;
      if (rxFire)
      begin
        rxSlot_r <= rxParSlot ? '0 : rxSlot_r + 1'b1;
        rxPar_r <= rxParSlot ? '0 : (rxPar_r ^ rxClient);
        if (!rxParSlot)
          rxLaneBits_r <= rxClient;
      end
    end
  end

  // Parity only detects; a block with any failing lane is uncorrectable
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blocks_r <= '0;
      uncorr_r <= '0;
      errBits_r <= '0;
      chkBits_r <= '0;
    end
    else if (linkInit)
    begin
      blocks_r <= '0;
      uncorr_r <= '0;
      errBits_r <= '0;
      chkBits_r <= '0;
    end
    else if (rxBlkEnd)
    begin
      blocks_r <= satAdd(blocks_r, CNT_W'(1));
      if (|rxMismatch)
        uncorr_r <= satAdd(uncorr_r, CNT_W'(1));
      errBits_r <= satAdd(errBits_r, rxErrN);
      chkBits_r <= satAdd(chkBits_r, BLK_BITS);
    end
  end

  assign satHit = rxBlkEnd && (blocks_r == CNT_MAX - 1'b1);
  assign irqEvent = {linkInit, satHit, rxBlkEnd && (|rxMismatch)};

  // A new event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      irqStat_r <= '0;
    else if (regWrite && regAddr == REG_IRQ_CLR)
      irqStat_r <= (irqStat_r & ~regWrData[IRQ_W-1:0]) | irqEvent;
    else
      irqStat_r <= irqStat_r | irqEvent;
  end

  assign irq = |(irqStat_r & irqEn_r);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mapReq_r <= MAP_RESET;
      irqEn_r <= IRQ_EN_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        REG_MAP_REQ: mapReq_r <= regWrData[MAP_W-1:0];
        REG_IRQ_EN: irqEn_r <= regWrData[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData_r <= '0;
    else if (regRead)
    begin
      case (regAddr)
        REG_MAP_REQ: regRdData_r <= DATA_W'(mapReq_r);
        REG_MAP_ACT: regRdData_r <= DATA_W'(mapAct_r);
        REG_IRQ_STAT: regRdData_r <= DATA_W'(irqStat_r);
        REG_IRQ_EN: regRdData_r <= DATA_W'(irqEn_r);
        REG_BLOCKS: regRdData_r <= DATA_W'(blocks_r);
        REG_UNCORR: regRdData_r <= DATA_W'(uncorr_r);
        REG_ERR_BITS: regRdData_r <= DATA_W'(errBits_r);
        REG_CHK_BITS: regRdData_r <= DATA_W'(chkBits_r);
        REG_LINK: regRdData_r <= DATA_W'(linkUp);
        default: regRdData_r <= '0;
      endcase
    end
    else
      regRdData_r <= '0;
  end

  a_map_fixed_up: assert property (@(posedge mclk) disable iff (!reset_n)
    !linkInit |=> $stable(mapAct_r))
    else $error("lane map changed without link init");

  a_map_taken_init: assert property (@(posedge mclk) disable iff (!reset_n)
    linkInit && mapIsPerm(mapReq_r) |=> mapAct_r == $past(mapReq_r))
    else $error("valid map request not taken at link init");

  a_tx_phase_step: assert property (@(posedge mclk) disable iff (!reset_n)
    txFire |=> txPhaseX_r == 2'($past(txPhaseX_r) + $past(txTurnX))
      && txPhaseY_r == 2'($past(txPhaseY_r) + $past(txTurnY)))
    else $error("transmit phase step wrong");

  a_parity_slot_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    txParSlot |-> !txReady)
    else $error("client accepted during parity slot");

  a_rx_roundtrip: assert property (@(posedge mclk) disable iff (!reset_n)
    rxFire && !rxParSlot && rxPhaseX == rxPrevX_r && rxPhaseY == rxPrevY_r
      |=> rxLaneValid_r && rxLaneBits_r == 4'h0)
    else $error("zero phase step did not decode to zeros");

  a_block_count: assert property (@(posedge mclk) disable iff (!reset_n)
    rxBlkEnd && blocks_r != CNT_MAX |=> blocks_r == $past(blocks_r) + 1'b1)
    else $error("block count did not advance");

  a_uncorr_count: assert property (@(posedge mclk) disable iff (!reset_n)
    rxBlkEnd && (|rxMismatch) && uncorr_r != CNT_MAX
      |=> uncorr_r == $past(uncorr_r) + 1'b1 && irqStat_r[IRQ_UNCORR])
    else $error("uncorrectable block not counted");

  a_ber_checked: assert property (@(posedge mclk) disable iff (!reset_n)
    rxBlkEnd && chkBits_r < CNT_MAX - BLK_BITS
      |=> chkBits_r == $past(chkBits_r) + BLK_BITS && errBits_r <= chkBits_r)
    else $error("checked bit tally wrong");

  a_count_restart: assert property (@(posedge mclk) disable iff (!reset_n)
    linkInit |=> blocks_r == '0 && uncorr_r == '0 && errBits_r == '0
      ##1 blocks_r <= CNT_W'(1))
    else $error("counters not cleared at link init");

  a_count_saturate: assert property (@(posedge mclk) disable iff (!reset_n)
    !linkInit && blocks_r == CNT_MAX |=> blocks_r == CNT_MAX)
    else $error("block counter wrapped");
endmodule : dqlm_core

// file: core/dqlm_pkg.sv
package dqlm_pkg;
  // Line figures; the datapath runs one symbol per mclk in a scaled model
  localparam real SYM_RATE_GBAUD = 27.95;
  localparam int unsigned SYM_PPM_TOL = 20;
  localparam real LINE_RATE_KBPS = 111809973.568;
  localparam int unsigned BITS_PER_SYM = 4;
  localparam int unsigned LOGICAL_PER_LANE = 5;
  localparam int unsigned LANE_N = 4;
  localparam int unsigned LANE_SEL_W = 2;
  localparam int unsigned MAP_W = 8;
  localparam int unsigned PHASE_W = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BLOCK_LEN_DEF = 16;
  localparam int unsigned CNT_W_DEF = 32;

  // Register map, byte addresses
  localparam logic [7:0] REG_MAP_REQ = 8'h00;
  localparam logic [7:0] REG_MAP_ACT = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_BLOCKS = 8'h14;
  localparam logic [7:0] REG_UNCORR = 8'h18;
  localparam logic [7:0] REG_ERR_BITS = 8'h1c;
  localparam logic [7:0] REG_CHK_BITS = 8'h20;
  localparam logic [7:0] REG_LINK = 8'h24;

  // Identity map: optical lane k carries client lane k
  localparam logic [7:0] MAP_RESET = 8'he4;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_UNCORR = 0;
  localparam int unsigned IRQ_SAT = 1;
  localparam int unsigned IRQ_INIT = 2;

  typedef enum logic [0:0]
  {
    DQLM_DOWN = 1'b0,
    DQLM_UP = 1'b1
  } dqlm_link_t;

  // Bit pair to quarter turns: 00 -> 0, 10 -> 1, 11 -> 2, 01 -> 3
  function automatic logic [1:0] dqlmPairToTurn(input logic firstPairBit,
                                                input logic secondPairBit);
    case ({firstPairBit, secondPairBit})
      2'b00: dqlmPairToTurn = 2'h0;
      2'b10: dqlmPairToTurn = 2'h1;
      2'b11: dqlmPairToTurn = 2'h2;
      default: dqlmPairToTurn = 2'h3;
    endcase
  endfunction : dqlmPairToTurn

  // Returns {firstPairBit, secondPairBit}
  function automatic logic [1:0] dqlmTurnToPair(input logic [1:0] turn);
    case (turn)
      2'h0: dqlmTurnToPair = 2'b00;
      2'h1: dqlmTurnToPair = 2'b10;
      2'h2: dqlmTurnToPair = 2'b11;
      default: dqlmTurnToPair = 2'b01;
    endcase
  endfunction : dqlmTurnToPair
endpackage : dqlm_pkg

// file: verif/dqlm_far_end.sv
`timescale 1ns/1ps
module dqlm_far_end (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [dqlm_pkg::PHASE_W-1:0] txPhaseX,
  input wire logic [dqlm_pkg::PHASE_W-1:0] txPhaseY,
  input wire logic txSymValid,
  input wire logic slip,
  output logic [dqlm_pkg::PHASE_W-1:0] rxPhaseX,
  output logic [dqlm_pkg::PHASE_W-1:0] rxPhaseY,
  output logic rxSymValid
);
  import dqlm_pkg::*;
  logic [PHASE_W-1:0] offX_r;
  logic [PHASE_W-1:0] slipAdd;

  // A slip rotates X by pi for good, so only one step is damaged
  assign slipAdd = slip ? 2'h2 : 2'h0;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      offX_r <= 2'h0;
      rxPhaseX <= 2'h0;
      rxPhaseY <= 2'h0;
      rxSymValid <= 1'b0;
    end
    else
    begin
      offX_r <= offX_r + slipAdd;
      rxSymValid <= txSymValid;
      // Parity symbols pass like data so the far decoder can check them
      if (txSymValid)
      begin
        // Absolute phase only; the receiver must work on differences
        rxPhaseX <= txPhaseX + offX_r + slipAdd;
        rxPhaseY <= txPhaseY;
      end
      else
      begin
        // Idle line: invert every cycle, so the last symbol is back on show every second idle cycle
        rxPhaseX <= ~rxPhaseX;
        rxPhaseY <= ~rxPhaseY;
      end
    end
  end
endmodule : dqlm_far_end

// file: verif/dqlm_core_tb.sv
`timescale 1ns/1ps
module dqlm_core_tb;
  import dqlm_pkg::*;
  localparam logic [1:0] PAIRS [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  // Third-to-fourth step also absorbs the parity symbol (pair 01)
  localparam logic [1:0] EXPPH [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic linkInit = 1'b0;
  logic linkDrop = 1'b0;
  logic [3:0] txLaneBits = 4'h0;
  logic txValid = 1'b0;
  logic txReady;
  logic [1:0] txPhaseX_r;
  logic [1:0] txPhaseY_r;
  logic txSymValid_r;
  logic [1:0] rxPhaseX;
  logic [1:0] rxPhaseY;
  logic rxSymValid;
  logic [3:0] rxLaneBits_r;
  logic rxLaneValid_r;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData_r;
  logic irq;
  logic slip = 1'b0;
  logic streamOn = 1'b0;
  logic chkRx = 1'b1;
  logic [3:0] sentQ [$];
  int miscompares = 0;
  int checks_done = 0;

  always #2 mclk = ~mclk;

  dqlm_core #(.BLOCK_LEN(4), .CNT_W(8)) u_dqlm_core (
    .mclk(mclk), .reset_n(reset_n), .linkInit(linkInit),
    .linkDrop(linkDrop), .txLaneBits(txLaneBits), .txValid(txValid),
    .txReady(txReady), .txPhaseX_r(txPhaseX_r), .txPhaseY_r(txPhaseY_r),
    .txSymValid_r(txSymValid_r), .rxPhaseX(rxPhaseX), .rxPhaseY(rxPhaseY),
    .rxSymValid(rxSymValid), .rxLaneBits_r(rxLaneBits_r),
    .rxLaneValid_r(rxLaneValid_r), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_r(regRdData_r), .irq(irq));

  dqlm_far_end u_dqlm_far_end (
    .mclk(mclk), .reset_n(reset_n), .txPhaseX(txPhaseX_r),
    .txPhaseY(txPhaseY_r), .txSymValid(txSymValid_r), .slip(slip),
    .rxPhaseX(rxPhaseX), .rxPhaseY(rxPhaseY), .rxSymValid(rxSymValid));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chkSig(input string nm, input logic [3:0] e,
                        input logic [3:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chkSig

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk32(nm, e, regRdData_r);
  endtask : rd

  task automatic send(input logic [3:0] b, input logic [1:0] e);
    @(posedge mclk);
    txValid <= 1'b1;
    txLaneBits <= b;
    @(negedge mclk);
    while (txReady !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    txValid <= 1'b0;
    #1;
    chkSig("phaseX", {2'h0, e}, {2'h0, txPhaseX_r});
    chkSig("phaseY", {2'h0, e}, {2'h0, txPhaseY_r});
  endtask : send

  task automatic pulse(input logic drop);
    @(posedge mclk);
    if (drop)
      linkDrop <= 1'b1;
    else
      linkInit <= 1'b1;
    @(posedge mclk);
    linkDrop <= 1'b0;
    linkInit <= 1'b0;
  endtask : pulse

  // Every accepted symbol must come back through the far end unchanged, except those skipped while chkRx is low around the slip
  always @(posedge mclk)
  begin
    if (txValid && txReady)
    begin
      sentQ.push_back(txLaneBits);
      if (streamOn)
        txLaneBits <= txLaneBits + 4'h3;
    end
    if (rxLaneValid_r === 1'b1 && sentQ.size() > 0)
    begin
      if (chkRx)
        chkSig("rxBits", sentQ[0], rxLaneBits_r);
      void'(sentQ.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(REG_MAP_REQ, 32'he4, "mapReq");
    rd(REG_MAP_ACT, 32'he4, "mapAct");
    rd(REG_LINK, 32'h0, "link");
    rd(8'hfc, 32'h0, "unmapped");
    chkSig("txReady", 4'h0, {3'h0, txReady});
    wr(REG_MAP_REQ, 32'h1b);
    rd(REG_MAP_ACT, 32'he4, "mapAct");
    pulse(1'b0);
    rd(REG_MAP_ACT, 32'h1b, "mapAct");
    rd(REG_LINK, 32'h1, "link");
    for (int i = 0; i < 4; i++)
      send({PAIRS[i], PAIRS[i]}, EXPPH[i]);
    wr(REG_MAP_REQ, 32'h4e);
    rd(REG_MAP_ACT, 32'h1b, "mapAct");
    @(posedge mclk);
    streamOn <= 1'b1;
    txValid <= 1'b1;
    repeat (200) @(posedge mclk);
    chkRx = 1'b0;
    slip <= 1'b1;
    @(posedge mclk);
    slip <= 1'b0;
    repeat (6) @(posedge mclk);
    chkRx = 1'b1;
    repeat (1000) @(posedge mclk);
    txValid <= 1'b0;
    streamOn <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(REG_BLOCKS, 32'hff, "blocks");
    rd(REG_UNCORR, 32'h1, "uncorr");
    rd(REG_ERR_BITS, 32'h2, "errBits");
    rd(REG_CHK_BITS, 32'hff, "chkBits");
    wr(REG_BLOCKS, 32'h0);
    rd(REG_BLOCKS, 32'hff, "blocksRo");
    rd(REG_IRQ_STAT, 32'h7, "irqStat");
    chkSig("irq", 4'h0, {3'h0, irq});
    wr(REG_IRQ_EN, 32'h2);
    chkSig("irq", 4'h1, {3'h0, irq});
    wr(REG_IRQ_CLR, 32'h7);
    chkSig("irq", 4'h0, {3'h0, irq});
    rd(REG_IRQ_STAT, 32'h0, "irqStat");
    rd(REG_IRQ_CLR, 32'h0, "irqClr");
    pulse(1'b1);
    rd(REG_LINK, 32'h0, "link");
    chkSig("txReady", 4'h0, {3'h0, txReady});
    pulse(1'b0);
    rd(REG_BLOCKS, 32'h0, "blocks");
    rd(REG_UNCORR, 32'h0, "uncorr");
    rd(REG_ERR_BITS, 32'h0, "errBits");
    rd(REG_CHK_BITS, 32'h0, "chkBits");
    rd(REG_MAP_ACT, 32'h4e, "mapAct");
    rd(REG_IRQ_STAT, 32'h4, "irqStat");
    end_sim();
  end
endmodule : dqlm_core_tb
